/* File: design/pwm_with_register_slave.sv */
/*
  Pulse-width modulator with a zero-wait word-addressed register slave.
  Assumes the host drives chip select, strobes, address and write data
  synchronously to core_clk; only one strobe is expected per cycle.
*/
// What this block does
// (RULE1) modulator and slave port share one clock.
// (RULE2) counter and comparator are 32 bits wide.
// (RULE3) counter advances each clock and wraps at the programmed period.
// (RULE4) output low while count at or below low-time, high above.
// (RULE5) offset 0 holds the period in clock cycles.
// (RULE6) offset 1 holds the low-time in clock cycles.
// (RULE7) offset 2 bit 0 enables the waveform.
// (RULE8) offset 3 is reserved with no function.
// (RULE9) period and low-time read back their last written value; the gate register reads back bit 0 only.
// (RULE10) host programs period, low-time and enable before using output.
// (RULE11) every read and write completes in one clock.
// (RULE12) read data answers in the same cycle as the read.
// (RULE13) no extra setup or hold cycles around transfers.
// (RULE14) a 2-bit word address selects whole 32-bit registers.
// (RULE15) active-low reset returns registers and counter to initial state.
// (RULE16) dedicated registers hold period and low-time for the core.
// (RULE17) period register resets to a build-time parameter.
// (RULE18) access only with chip select plus read or write strobe.
// (RULE19) disabled holds counter and output at zero; reserved reads zero.
`timescale 1ns/1ns
`default_nettype none
module pwm_with_register_slave #(
  parameter logic [31:0] PERIOD_INIT = pwm_pkg::PERIOD_RESET
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register slave port
  input wire logic chipSelect,
  input wire logic [pwm_pkg::ADDR_W-1:0] address,
  input wire logic write,
  input wire logic [pwm_pkg::DATA_W-1:0] writeData,
  input wire logic read,
  output logic [pwm_pkg::DATA_W-1:0] readData,
  // waveform
  output logic pulseOut
);
  import pwm_pkg::*;

  logic [DATA_W-1:0] period_reg;
  logic [DATA_W-1:0] lowTime_reg;
  logic gate_reg;
  logic [DATA_W-1:0] readMux;
  wire logic wrAccess;
  wire logic rdAccess;
  wire logic wrPeriod;
  wire logic wrLowTime;
  wire logic wrGate;
  wire logic taskPulse;
  wire logic [DATA_W-1:0] countValue;

  // one-hot word decode, shared by write steering
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs); // [RULE14]
  endfunction

  // strobes only count together with chip select
  assign wrAccess = chipSelect && write; // [RULE18]
  assign rdAccess = chipSelect && read; // [RULE18]
  assign wrPeriod = wrAccess && hit(address, OFS_PERIOD); // [RULE5]
  assign wrLowTime = wrAccess && hit(address, OFS_LOW_TIME); // [RULE6]
  assign wrGate = wrAccess && hit(address, OFS_GATE); // [RULE7]

  // read mux is combinational so data meets the read in its own cycle;
  // the trade-off is that readData is not a flop, as zero latency demands
  always_comb begin
    readMux = READ_IDLE;
    if (rdAccess) begin // [RULE12] [RULE13]
      case (address)
        OFS_PERIOD: readMux = period_reg; // [RULE9]
        OFS_LOW_TIME: readMux = lowTime_reg; // [RULE9]
        OFS_GATE: readMux = {31'h0, gate_reg}; // [RULE9]
        OFS_RESERVED: readMux = READ_IDLE; // [RULE8] [RULE19]
        default: readMux = READ_IDLE;
      endcase
    end
  end
  assign readData = readMux;

  // writes land at the clock edge that ends the single-cycle transfer
  always_ff @(posedge core_clk or negedge rst_b) begin // [RULE11] [RULE15] [RULE16]
    if (!rst_b) begin
      period_reg <= PERIOD_INIT; // [RULE17]
      lowTime_reg <= LOW_TIME_RESET;
      gate_reg <= GATE_RESET;
    end else begin
      if (wrPeriod) begin
        period_reg <= writeData;
      end
      if (wrLowTime) begin
        lowTime_reg <= writeData;
      end
      if (wrGate) begin
        gate_reg <= writeData[GATE_BIT]; // [RULE7]
      end
    end
  end

  // core runs on the same clock as the slave
  pwm_task_logic pwm_task_logic_inst ( // [RULE1]
    .core_clk(core_clk),
    .rst_b(rst_b),
    .gateOn(gate_reg),
    .periodCycles(period_reg),
    .lowTimeCycles(lowTime_reg),
    .pulseOut(taskPulse),
    .countValue(countValue)
  );
  assign pulseOut = taskPulse;

  property p_write_period;
    @(posedge core_clk) disable iff (!rst_b)
      wrPeriod |=> (period_reg == $past(writeData));
  endproperty
  a_write_period: assert property (p_write_period) else $error("period write lost"); // [RULE5]

  property p_write_low;
    @(posedge core_clk) disable iff (!rst_b)
      wrLowTime |=> (lowTime_reg == $past(writeData));
  endproperty
  a_write_low: assert property (p_write_low) else $error("low time write lost"); // [RULE6]

  property p_write_gate;
    @(posedge core_clk) disable iff (!rst_b)
      wrGate |=> (gate_reg == $past(writeData[0]));
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("gate write lost"); // [RULE7]

  property p_no_strobe_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !wrAccess |=> $stable(period_reg) && $stable(lowTime_reg) && $stable(gate_reg);
  endproperty
  a_no_strobe_hold: assert property (p_no_strobe_hold) // [RULE18]
    else $error("register changed without write");

  property p_read_period;
    @(posedge core_clk) disable iff (!rst_b)
      (rdAccess && address == 2'h0) |-> readData == period_reg;
  endproperty
  a_read_period: assert property (p_read_period) else $error("period read wrong"); // [RULE9]

  property p_read_reserved;
    @(posedge core_clk) disable iff (!rst_b)
      (rdAccess && address == 2'h3) |-> readData == 32'h0;
  endproperty
  a_read_reserved: assert property (p_read_reserved) // [RULE8]
    else $error("reserved read not zero");

  sequence s_write_then_read;
    (wrLowTime && !rdAccess) ##1 (rdAccess && address == 2'h1 && !wrAccess);
  endsequence
  property p_readback;
    @(posedge core_clk) disable iff (!rst_b)
      s_write_then_read |-> readData == $past(writeData);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch"); // [RULE12]

  property p_read_low;
    @(posedge core_clk) disable iff (!rst_b)
      (rdAccess && address == OFS_LOW_TIME) |-> readData == lowTime_reg;
  endproperty
  a_read_low: assert property (p_read_low) // [RULE9]
    else $error("low time read wrong");

  property p_read_gate;
    @(posedge core_clk) disable iff (!rst_b)
      (rdAccess && address == OFS_GATE) |-> readData[GATE_BIT] == gate_reg;
  endproperty
  a_read_gate: assert property (p_read_gate) // [RULE9]
    else $error("gate read wrong");

  property p_read_gate_upper;
    @(posedge core_clk) disable iff (!rst_b)
      (rdAccess && address == OFS_GATE) |-> readData[DATA_W-1:1] == 31'h0;
  endproperty
  a_read_gate_upper: assert property (p_read_gate_upper) // [RULE7]
    else $error("gate read shows upper bits");

  // an idle bus reads as zero so a host never latches stale data
  property p_read_idle;
    @(posedge core_clk) disable iff (!rst_b)
      !rdAccess |-> readData == READ_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle) // [RULE18]
    else $error("read data without a selected read");

  // write side: the reserved slot and unaddressed registers keep their contents
  property p_reserved_write;
    @(posedge core_clk) disable iff (!rst_b)
      (wrAccess && address == OFS_RESERVED) |=>
        $stable(period_reg) && $stable(lowTime_reg) && $stable(gate_reg);
  endproperty
  a_reserved_write: assert property (p_reserved_write) // [RULE8] [RULE19]
    else $error("reserved write changed a register");

  property p_period_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !wrPeriod |=> $stable(period_reg);
  endproperty
  a_period_hold: assert property (p_period_hold) // [RULE16]
    else $error("period changed without its write");

  property p_low_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !wrLowTime |=> $stable(lowTime_reg);
  endproperty
  a_low_hold: assert property (p_low_hold) // [RULE16]
    else $error("low time changed without its write");

  property p_gate_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !wrGate |=> $stable(gate_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) // [RULE7]
    else $error("gate changed without its write");

  // a read right after a write must already see the new value
  sequence s_period_readback;
    (wrPeriod && !rdAccess) ##1 (rdAccess && address == OFS_PERIOD && !wrAccess);
  endsequence
  property p_period_readback;
    @(posedge core_clk) disable iff (!rst_b)
      s_period_readback |-> readData == $past(writeData);
  endproperty
  a_period_readback: assert property (p_period_readback) // [RULE9] [RULE12]
    else $error("period readback mismatch");

  sequence s_gate_readback;
    (wrGate && !rdAccess) ##1 (rdAccess && address == OFS_GATE && !wrAccess);
  endsequence
  property p_gate_readback;
    @(posedge core_clk) disable iff (!rst_b)
      s_gate_readback |-> readData[GATE_BIT] == $past(writeData[GATE_BIT]);
  endproperty
  a_gate_readback: assert property (p_gate_readback) // [RULE9]
    else $error("gate readback mismatch");

  // back-to-back writes land in successive cycles with no gap between them
  sequence s_low_then_gate;
    wrLowTime ##1 wrGate;
  endsequence
  property p_low_then_gate;
    @(posedge core_clk) disable iff (!rst_b)
      s_low_then_gate |=> lowTime_reg == $past(writeData, 2) &&
        gate_reg == $past(writeData[GATE_BIT]);
  endproperty
  a_low_then_gate: assert property (p_low_then_gate) // [RULE11] [RULE13]
    else $error("back-to-back writes lost");

  // core view: a period change takes one cycle to pull the counter back in range
  property p_count_below_period;
    @(posedge core_clk) disable iff (!rst_b)
      (period_reg != 32'h0 && $stable(period_reg)) |-> countValue < period_reg;
  endproperty
  a_count_below_period: assert property (p_count_below_period) // [RULE3]
    else $error("count reached the period");

  property p_count_step;
    @(posedge core_clk) disable iff (!rst_b)
      (gate_reg && period_reg > 32'h1 && countValue < period_reg - 32'h1) |=>
        countValue == $past(countValue) + 32'h1;
  endproperty
  a_count_step: assert property (p_count_step) // [RULE3]
    else $error("count did not step");

  property p_count_wrap;
    @(posedge core_clk) disable iff (!rst_b)
      (gate_reg && period_reg != 32'h0 && countValue == period_reg - 32'h1) |=>
        countValue == COUNT_RESET;
  endproperty
  a_count_wrap: assert property (p_count_wrap) // [RULE3]
    else $error("count did not wrap at period");

  // enabling starts the period from zero, so the first cycle is always low
  sequence s_gate_rise;
    $rose(gate_reg);
  endsequence
  property p_gate_rise;
    @(posedge core_clk) disable iff (!rst_b)
      s_gate_rise |-> countValue == COUNT_RESET;
  endproperty
  a_gate_rise: assert property (p_gate_rise) // [RULE19]
    else $error("count not zero at enable");

  property p_first_step;
    @(posedge core_clk) disable iff (!rst_b)
      (s_gate_rise ##0 (period_reg > 32'h1)) |=> countValue == 32'h0000_0001;
  endproperty
  a_first_step: assert property (p_first_step) // [RULE3]
    else $error("count did not start after enable");

  property p_disabled_count;
    @(posedge core_clk) disable iff (!rst_b)
      !gate_reg |=> countValue == COUNT_RESET;
  endproperty
  a_disabled_count: assert property (p_disabled_count) // [RULE19]
    else $error("count runs while disabled");

  property p_disabled_pulse;
    @(posedge core_clk) disable iff (!rst_b)
      !gate_reg |=> !pulseOut;
  endproperty
  a_disabled_pulse: assert property (p_disabled_pulse) // [RULE19]
    else $error("output high while disabled");

  property p_pulse_low;
    @(posedge core_clk) disable iff (!rst_b)
      (countValue <= lowTime_reg && $stable(lowTime_reg)) |-> !pulseOut;
  endproperty
  a_pulse_low: assert property (p_pulse_low) // [RULE4]
    else $error("pin high at or below low time");

  property p_pulse_high;
    @(posedge core_clk) disable iff (!rst_b)
      (gate_reg && $stable(gate_reg) && $stable(lowTime_reg) && countValue > lowTime_reg)
        |-> pulseOut;
  endproperty
  a_pulse_high: assert property (p_pulse_high) // [RULE4]
    else $error("pin low above low time");
endmodule
`default_nettype wire

/* File: design/pwm_pkg.sv */
/*
  Shared constants for the pulse-width modulator: register word offsets,
  field positions, reset values and bus widths.
  Assumes a single 100 MHz core clock and a 2-bit word-addressed slave port.
*/
package pwm_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 2;
  // word offsets of the register file
  localparam logic [1:0] OFS_PERIOD = 2'h0;
  localparam logic [1:0] OFS_LOW_TIME = 2'h1;
  localparam logic [1:0] OFS_GATE = 2'h2;
  localparam logic [1:0] OFS_RESERVED = 2'h3;
  // enable bit position within the gate register
  localparam int GATE_BIT = 0;
  // values after reset
  localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
  localparam logic [31:0] LOW_TIME_RESET = 32'h0000_0000;
  localparam logic GATE_RESET = 1'b0;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;
endpackage

/* File: design/pwm_task_logic.sv */
/*
  Modulation core: a wrapping period counter and a low-time comparator.
  Assumes period and low-time come from registers on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pwm_task_logic (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // settings
  input wire logic gateOn,
  input wire logic [pwm_pkg::DATA_W-1:0] periodCycles,
  input wire logic [pwm_pkg::DATA_W-1:0] lowTimeCycles,
  // waveform
  output logic pulseOut,
  output logic [pwm_pkg::DATA_W-1:0] countValue
);
  import pwm_pkg::*;

  logic [DATA_W-1:0] count_reg;
  logic [DATA_W-1:0] count_next;
  logic pulse_reg;
  logic pulse_next;
  wire logic wrapNow;

  // wrap at period-1; a period of 0 or 1 keeps the counter at zero
  assign wrapNow = (count_reg >= periodCycles - 32'h0000_0001) || (periodCycles == 32'h0);
  assign count_next = !gateOn ? COUNT_RESET : // [RULE19]
                      wrapNow ? COUNT_RESET : count_reg + 32'h0000_0001; // [RULE3] [RULE2]
  // output is decided from the next count, so it is a pure flop aligned with the counter
  assign pulse_next = gateOn && (count_next > lowTimeCycles); // [RULE4] [RULE19]

  // single clock domain for the whole core
  always_ff @(posedge core_clk or negedge rst_b) begin // [RULE1] [RULE15]
    if (!rst_b) begin
      count_reg <= COUNT_RESET;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulseOut = pulse_reg;
  assign countValue = count_reg;

  property p_low_when_below;
    @(posedge core_clk) disable iff (!rst_b)
      // the flop holds a decision made against last cycle's low time
      (count_reg <= lowTimeCycles && $stable(lowTimeCycles)) |-> !pulse_reg;
  endproperty
  a_low_when_below: assert property (p_low_when_below) // [RULE4]
    else $error("output high at or below low time");

  property p_high_when_above;
    @(posedge core_clk) disable iff (!rst_b)
      (gateOn && $stable(gateOn) && $stable(lowTimeCycles) && count_reg > lowTimeCycles)
        |-> pulse_reg;
  endproperty
  a_high_when_above: assert property (p_high_when_above) // [RULE4]
    else $error("output low above low time");

  property p_count_steps;
    @(posedge core_clk) disable iff (!rst_b)
      (gateOn && !wrapNow) |=> (count_reg == $past(count_reg) + 32'h0000_0001);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("counter did not advance"); // [RULE3]

  property p_count_wraps;
    @(posedge core_clk) disable iff (!rst_b)
      wrapNow |=> (count_reg == 32'h0);
  endproperty
  a_count_wraps: assert property (p_count_wraps) else $error("counter did not wrap"); // [RULE3]

  property p_count_bounded;
    @(posedge core_clk) disable iff (!rst_b)
      (periodCycles != 32'h0 && $stable(periodCycles)) |->
        count_reg < periodCycles || $past(count_reg) >= periodCycles;
  endproperty
  a_count_bounded: assert property (p_count_bounded) // [RULE2]
    else $error("counter passed period");

  sequence s_gate_off;
    !gateOn;
  endsequence
  property p_idle_off;
    @(posedge core_clk) disable iff (!rst_b)
      s_gate_off |=> (count_reg == 32'h0 && !pulse_reg);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("disabled core not idle"); // [RULE19]
endmodule
`default_nettype wire

/* File: tb/pwm_host_model.sv */
/*
  Host processor model for the modulator's register slave port.
  Assumes core_clk comes from the bench and each task is entered just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pwm_host_model (
  // clock
  input wire logic core_clk,
  // slave port
  output logic chipSelect,
  output logic [pwm_pkg::ADDR_W-1:0] address,
  output logic write,
  output logic [pwm_pkg::DATA_W-1:0] writeData,
  output logic read,
  input wire logic [pwm_pkg::DATA_W-1:0] readData
);
  import pwm_pkg::*;
  // bus idles deselected from time zero
  initial begin
    chipSelect = 1'b0;
    address = 2'h0;
    write = 1'b0;
    writeData = 32'h0000_0000;
    read = 1'b0;
  end
  // one transfer; signals stay up so the next call can follow back to back
  task automatic xfer(input logic cs, input logic wr, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    chipSelect = cs;
    write = wr;
    read = !wr;
    address = a;
    writeData = d;
    @(posedge core_clk);
    q = readData; // zero-latency answer taken at the sampling edge
    #1;
  endtask
  // release: address and data flip so a stale value cannot pass for a live one
  task automatic idle();
    chipSelect = 1'b0;
    write = 1'b0;
    read = 1'b0;
    address = ~address;
    writeData = ~writeData;
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: tb/pwm_with_register_slave_test.sv */
/*
  Self-checking bench for the modulator with its register slave.
  Assumes the host model drives the slave port; inputs change 1 ns after the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pwm_with_register_slave_test;
  import pwm_pkg::*;
  localparam logic [31:0] INIT = 32'h0000_0007;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic chipSelect, write, read, pulseOut;
  logic [1:0] address;
  logic [31:0] writeData, readData;
  int error_cnt = 0;
  int checks = 0;
  always #5 core_clk = ~core_clk;
  pwm_with_register_slave #(.PERIOD_INIT(INIT)) pwm_with_register_slave_inst (.core_clk(core_clk),
    .rst_b(rst_b), .chipSelect(chipSelect), .address(address), .write(write),
    .writeData(writeData), .read(read), .readData(readData), .pulseOut(pulseOut));
  pwm_host_model pwm_host_model_inst (.core_clk(core_clk), .chipSelect(chipSelect),
    .address(address), .write(write), .writeData(writeData), .read(read), .readData(readData));
  // compare and count; x or z never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    logic [31:0] q;
    pwm_host_model_inst.xfer(1'b1, 1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [31:0] e);
    logic [31:0] q;
    pwm_host_model_inst.xfer(1'b1, 1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // ones on pulseOut over n cycles
  task automatic count_high(input int n, output logic [31:0] ones);
    ones = 32'h0000_0000;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      ones = ones + {31'h0, pulseOut};
    end
  endtask
  task automatic reset_values();
    rd_chk(OFS_PERIOD, INIT);
    rd_chk(OFS_LOW_TIME, 32'h0000_0000);
    rd_chk(OFS_GATE, 32'h0000_0000);
    rd_chk(OFS_RESERVED, 32'h0000_0000);
    chk({31'h0, pulseOut}, 32'h0000_0000);
    pwm_host_model_inst.idle();
  endtask
  // period, low-time and gate writes read back in the next cycle; reserved slot and unselected strobes are ignored
  task automatic register_access();
    logic [31:0] q;
    wr(OFS_PERIOD, 32'hA5A5_5A5A);
    rd_chk(OFS_PERIOD, 32'hA5A5_5A5A);
    wr(OFS_LOW_TIME, 32'h1234_5678);
    rd_chk(OFS_LOW_TIME, 32'h1234_5678);
    wr(OFS_RESERVED, 32'hFFFF_FFFF);
    wr(OFS_GATE, 32'hFFFF_FFFE);
    rd_chk(OFS_GATE, 32'h0000_0000);
    rd_chk(OFS_RESERVED, 32'h0000_0000);
    pwm_host_model_inst.xfer(1'b0, 1'b1, OFS_PERIOD, 32'h0000_0003, q);
    pwm_host_model_inst.xfer(1'b0, 1'b0, OFS_PERIOD, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    rd_chk(OFS_PERIOD, 32'hA5A5_5A5A);
    pwm_host_model_inst.idle();
  endtask
  // period 5: count runs 0..4 and is high above low-time, so high cycles = 4 - low
  task automatic waveform();
    logic [31:0] ones;
    wr(OFS_PERIOD, 32'h0000_0005);
    wr(OFS_GATE, 32'h0000_0001);
    rd_chk(OFS_GATE, 32'h0000_0001);
    for (int low = 0; low <= 5; low++) begin
      wr(OFS_LOW_TIME, 32'(low));
      pwm_host_model_inst.idle();
      repeat (6) @(posedge core_clk);
      #1;
      count_high(5, ones);
      chk(ones, (low < 4) ? 32'(4 - low) : 32'h0000_0000);
    end
  endtask
  task automatic disable_output();
    logic [31:0] ones;
    wr(OFS_LOW_TIME, 32'h0000_0000);
    wr(OFS_GATE, 32'h0000_0000);
    pwm_host_model_inst.idle();
    count_high(12, ones);
    chk(ones, 32'h0000_0000);
  endtask
  // reset in mid-run with the counter running and the output held low
  task automatic mid_reset();
    wr(OFS_LOW_TIME, 32'hFFFF_0000);
    wr(OFS_GATE, 32'h0000_0001);
    pwm_host_model_inst.idle();
    rst_b = 1'b0;
    #20;
    rst_b = 1'b1;
    reset_values();
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // reset for 3 cycles, release just after an edge, then run each scenario
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    reset_values();
    register_access();
    waveform();
    disable_output();
    mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
